// [src/ppe_defines.svh]
// Purpose: Constants for the parallel program/erase control block.
// Assumes: 40 MHz clock; memory controllers outside answer with done pulses.
// Notes:   Included by the package-using design files.
`ifndef PPE_DEFINES_SVH
`define PPE_DEFINES_SVH
`define PPE_CMD_W         8
`define PPE_CMD_CHIP_ERASE 8'h80
`define PPE_CMD_WR_FLASH  8'h10
`define PPE_CMD_WR_EEPROM 8'h11
`define PPE_CMD_RD_FLASH  8'h02
`define PPE_CMD_RD_EEPROM 8'h03
`define PPE_CMD_RD_SIG    8'h08
`define PPE_ERASED_BYTE   8'hFF
`define PPE_LOCK_W        8
`define PPE_LOCK_RESET    8'hFF
`define PPE_LOCK_ERASED   8'hFF
`endif

// [src/ppe_pkg.sv]
// Purpose: Types shared by the program/erase control block.
// Assumes: Constants come from ppe_defines.svh.
// Notes:   States are one-hot.
package ppe_pkg;
  typedef enum logic [3:0] {
    PPE_IDLE      = 4'h1,
    PPE_ER_FLASH  = 4'h2,
    PPE_ER_EEPROM = 4'h4,
    PPE_ER_LOCK   = 4'h8
  } ppe_state_type;
endpackage

// [src/ppe_sync.sv]
// Purpose: Two-stage synchroniser for one pin input.
// Assumes: Input is asynchronous to clk.
// Notes:   Stage one feeds only stage two.
module ppe_sync (
  input  wire logic clk,     // System clock.
  input  wire logic reset_n, // Asynchronous reset, active low.
  input  wire logic d,       // Asynchronous input.
  output logic      q        // Synchronised output.
);
  logic meta;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// [src/ppe_ctrl.sv]
// Purpose: Command/address retention and chip erase sequencing of the parallel programming port.
// Assumes: Load strobes and data come from external pins; erase engines answer with done pulses.
// Notes:   Load strobes are levels on pins; each rising edge after synchronising is one load while idle.
// How it works
// - Loaded command kept for many accesses.
// - High address byte kept across accesses.
// - Same retention applies to signature reads.
// - Chip erase clears flash, lock bits, and EEPROM unless the keep fuse is programmed.
// - Lock bits released after flash erase completes.
// - Chip erase never touches fuse bits.
// - Keep fuse programmed preserves EEPROM contents.
// - Command and address held until reloaded.
`include "ppe_defines.svh"
module ppe_ctrl
  import ppe_pkg::*;
(
  input  wire logic                   clk,              // 40 MHz system clock.
  input  wire logic                   reset_n,          // Asynchronous reset, active low.
  input  wire logic                   load_cmd_pin,     // Pin: rising edge loads command.
  input  wire logic                   load_addr_lo_pin, // Pin: rising edge loads low address byte.
  input  wire logic                   load_addr_hi_pin, // Pin: rising edge loads high address byte.
  input  wire logic [7:0]             data_pin,         // Pin: command or address byte.
  input  wire logic                   eeprom_keep_fuse, // Fuse level, 1 when programmed.
  input  wire logic                   flash_erase_done, // Pulse: flash erase finished.
  input  wire logic                   eeprom_erase_done,// Pulse: EEPROM erase finished.
  output logic [`PPE_CMD_W-1:0]       cmd,              // Retained command.
  output logic [15:0]                 addr,             // Retained address, high then low byte.
  output logic                        flash_erase_req,  // Level: flash erase in progress.
  output logic                        eeprom_erase_req, // Level: EEPROM erase in progress.
  output logic [`PPE_LOCK_W-1:0]      lock_bits,        // Lock bits, all ones when unprogrammed.
  output logic                        erase_busy        // Level: chip erase sequence running.
);
  typedef struct packed {
    ppe_state_type          state;
    logic [`PPE_CMD_W-1:0]  cmd;
    logic [15:0]            addr;
    logic                   flash_req;
    logic                   eeprom_req;
    logic [`PPE_LOCK_W-1:0] lock;
    logic                   busy;
    logic                   cmd_prev;
    logic                   lo_prev;
    logic                   hi_prev;
    logic [7:0]             data_s1;
    logic [7:0]             data_s2;
  } ppe_regs_type;

  ppe_regs_type r;
  ppe_regs_type next_r;
  logic         cmd_s;
  logic         lo_s;
  logic         hi_s;
  logic         cmd_edge;
  logic         lo_edge;
  logic         hi_edge;

  ppe_sync u_sync_cmd (.clk(clk), .reset_n(reset_n), .d(load_cmd_pin),     .q(cmd_s));
  ppe_sync u_sync_lo  (.clk(clk), .reset_n(reset_n), .d(load_addr_lo_pin), .q(lo_s));
  ppe_sync u_sync_hi  (.clk(clk), .reset_n(reset_n), .d(load_addr_hi_pin), .q(hi_s));

  assign cmd_edge = cmd_s & ~r.cmd_prev;
  assign lo_edge  = lo_s & ~r.lo_prev;
  assign hi_edge  = hi_s & ~r.hi_prev;

  always_comb begin
    next_r          = r;
    next_r.cmd_prev = cmd_s;
    next_r.lo_prev  = lo_s;
    next_r.hi_prev  = hi_s;
    // The data bus settles well before a strobe; two stages match the strobe delay.
    next_r.data_s1  = data_pin;
    next_r.data_s2  = r.data_s1;

    // Loads are refused while an erase runs so the sequence cannot be corrupted.
    if (r.state == PPE_IDLE) begin
      if (cmd_edge) begin
        next_r.cmd = r.data_s2;
      end
      if (lo_edge) begin
        next_r.addr[7:0] = r.data_s2;
      end
      if (hi_edge) begin
        // Only this load changes the window, so any access kind reuses it.
        next_r.addr[15:8] = r.data_s2;
      end
    end

    case (r.state)
      PPE_IDLE: begin
        if (cmd_edge && r.data_s2 == `PPE_CMD_CHIP_ERASE) begin
          next_r.state     = PPE_ER_FLASH;
          next_r.flash_req = 1'b1;
          next_r.busy      = 1'b1;
        end
      end
      PPE_ER_FLASH: begin
        if (flash_erase_done) begin
          next_r.flash_req = 1'b0;
          if (eeprom_keep_fuse) begin
            next_r.state = PPE_ER_LOCK;
          end else begin
            next_r.state      = PPE_ER_EEPROM;
            next_r.eeprom_req = 1'b1;
          end
        end
      end
      PPE_ER_EEPROM: begin
        if (eeprom_erase_done) begin
          next_r.eeprom_req = 1'b0;
          next_r.state      = PPE_ER_LOCK;
        end
      end
      PPE_ER_LOCK: begin
        // Reached only after flash done; no fuse output exists, so fuses stay as they are.
        next_r.lock  = `PPE_LOCK_ERASED;
        next_r.busy  = 1'b0;
        next_r.state = PPE_IDLE;
      end
      default: begin
        next_r.state      = PPE_IDLE;
        next_r.flash_req  = 1'b0;
        next_r.eeprom_req = 1'b0;
        next_r.busy       = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r.state      <= PPE_IDLE;
      r.cmd        <= '0;
      r.addr       <= '0;
      r.flash_req  <= 1'b0;
      r.eeprom_req <= 1'b0;
      r.lock       <= `PPE_LOCK_RESET;
      r.busy       <= 1'b0;
      r.cmd_prev   <= 1'b0;
      r.lo_prev    <= 1'b0;
      r.hi_prev    <= 1'b0;
      r.data_s1    <= '0;
      r.data_s2    <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign cmd              = r.cmd;
  assign addr             = r.addr;
  assign flash_erase_req  = r.flash_req;
  assign eeprom_erase_req = r.eeprom_req;
  assign lock_bits        = r.lock;
  assign erase_busy       = r.busy;
endmodule

// [tb/ppe_ctrl_sva.sv]
// Purpose: Port assertions for ppe_ctrl.
// Assumes: One clock domain.
// Notes:   Bound from the bench file.
module ppe_ctrl_chk (
  input wire logic        clk,               // Clock.
  input wire logic        reset_n,           // Reset.
  input wire logic        load_cmd_pin,      // Strobe.
  input wire logic        load_addr_lo_pin,  // Strobe.
  input wire logic        load_addr_hi_pin,  // Strobe.
  input wire logic [7:0]  data_pin,          // Byte.
  input wire logic        eeprom_keep_fuse,  // Fuse.
  input wire logic        flash_erase_done,  // Done.
  input wire logic        eeprom_erase_done, // Done.
  input wire logic [7:0]  cmd,               // Command.
  input wire logic [15:0] addr,              // Address.
  input wire logic        flash_erase_req,   // Request.
  input wire logic        eeprom_erase_req,  // Request.
  input wire logic [7:0]  lock_bits,         // Lock.
  input wire logic        erase_busy         // Busy.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_fdone; flash_erase_done && flash_erase_req; endsequence
  sequence s_free; !erase_busy && lock_bits == 8'hFF; endsequence
  AST_CMD_LOAD: assert property ($changed(cmd) |-> $past(load_cmd_pin, 3) && !$past(load_cmd_pin, 4))
    else $error("command moved without a load");
  AST_HI_LOAD: assert property ($changed(addr[15:8]) |-> $past(load_addr_hi_pin, 3) && !$past(load_addr_hi_pin, 4))
    else $error("high byte moved without a load");
  AST_LO_LOAD: assert property ($changed(addr[7:0]) |-> $past(load_addr_lo_pin, 3) && !$past(load_addr_lo_pin, 4))
    else $error("low byte moved without a load");
  AST_SIG_KEEP: assert property ($changed(cmd) |-> $stable(addr))
    else $error("address lost on command load");
  AST_ERASE_GO: assert property ($changed(cmd) && cmd == 8'h80 |-> flash_erase_req && erase_busy)
    else $error("erase did not start");
  AST_EE_GO: assert property (s_fdone ##0 !eeprom_keep_fuse |=> eeprom_erase_req && erase_busy && !flash_erase_req)
    else $error("eeprom erase did not follow");
  AST_EE_KEEP: assert property (s_fdone ##0 eeprom_keep_fuse |=> !eeprom_erase_req ##1 s_free)
    else $error("kept eeprom touched or lock late");
  AST_LOCK_LATE: assert property (eeprom_erase_done && eeprom_erase_req |=> !eeprom_erase_req && erase_busy ##1 s_free)
    else $error("lock release out of order");
endmodule

// [tb/ppe_prog_model.sv]
// Purpose: Programmer side of the load pins.
// Assumes: Called only at falling edges.
// Notes:   The byte is inverted once its hold ends, so stale data is never seen.
// After an erase no erased-pattern words are written, and no write precedes an erase.
module ppe_prog_model (
  input  wire logic       clk,              // Clock.
  output logic            load_cmd_pin,     // Strobe.
  output logic            load_addr_lo_pin, // Strobe.
  output logic            load_addr_hi_pin, // Strobe.
  output logic [7:0]      data_pin          // Byte.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] stb = '0;
  initial data_pin = '0;
  assign {load_addr_hi_pin, load_addr_lo_pin, load_cmd_pin} = stb;
  task automatic load(input int k, input logic [7:0] b);
    data_pin = b;
    repeat (3) @(negedge clk);
    stb[k] = 1'b1;
    repeat (3) @(negedge clk);
    stb[k] = 1'b0;
    repeat (3) @(negedge clk);
    data_pin = ~b;
    @(negedge clk);
  endtask
endmodule

// [tb/test_parallel_program_erase_control.sv]
// Purpose: Self-checking bench for ppe_ctrl.
// Assumes: Inputs change on falling edges.
// Notes:   Erase engines are single done pulses driven here.
module test_parallel_program_erase_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, keep = 0, fdone = 0, edone = 0;
  wire logic lc, llo, lhi, freq, ereq, erase_busy;
  wire logic [7:0] d, cmd, lock_bits;
  wire logic [15:0] addr;
  int err_count = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  ppe_prog_model pm (.clk(clk), .load_cmd_pin(lc), .load_addr_lo_pin(llo), .load_addr_hi_pin(lhi), .data_pin(d));
  ppe_ctrl dut (.clk(clk), .reset_n(reset_n), .load_cmd_pin(lc), .load_addr_lo_pin(llo), .load_addr_hi_pin(lhi),
    .data_pin(d), .eeprom_keep_fuse(keep), .flash_erase_done(fdone), .eeprom_erase_done(edone), .cmd(cmd),
    .addr(addr), .flash_erase_req(freq), .eeprom_erase_req(ereq), .lock_bits(lock_bits), .erase_busy(erase_busy));
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task t_retain;
    pm.load(0, 8'h02);
    pm.load(2, 8'h12);
    pm.load(1, 8'h34);
    pm.load(1, 8'h35);
    chk(cmd, 8'h02);
    chk(addr, 16'h1235);
    pm.load(0, 8'h08);
    pm.load(1, 8'h00);
    chk(addr, 16'h1200);
    $display("retain test done");
  endtask
  task t_erase(input logic k);
    keep = k;
    pm.load(0, 8'h80);
    chk({erase_busy, freq}, 2'b11);
    pm.load(1, 8'hAA);
    chk(addr, 16'h1200);
    fdone = 1;
    @(negedge clk);
    chk({erase_busy, freq, ereq}, {2'b10, !k});
    fdone = 0;
    @(negedge clk);
    chk({erase_busy, freq, ereq}, {!k, 1'b0, !k});
    if (!k) begin
      edone = 1;
      @(negedge clk);
      chk({erase_busy, ereq}, 2'b10);
      edone = 0;
    end
    @(negedge clk);
    chk({erase_busy, lock_bits}, 9'h0FF);
    $display("erase test done");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1;
    t_retain;
    t_erase(1);
    t_erase(0);
    stop_test;
  end
  initial begin
    #50us;
    err_count++;
    stop_test;
  end
endmodule
bind ppe_ctrl ppe_ctrl_chk chk (.*);
